// [hw/power_up_reset_and_config_word.sv]
// Behaviour
// - cold reset always runs 64 ms delay timer; power-on detect runs it only when power-up bit is programmed
// - crystal modes wait for oscillator start-up timer
// - brown-out resets, then 64 ms delay timer
// - sleep ends on reset, watchdog or interrupt
// - config bits: programmed 0, unprogrammed 1
// - config word lives at program address 2007h
// - config space reachable only in programming mode
// - oscillator option chosen by config bits
`timescale 1ns/10ps
`include "power_up_reset_regs.svh"
module power_up_reset_and_config_word #(
    parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `POWER_UP_DELAY_TIMER_CYCLES,
    parameter int unsigned OST_CYCLES = `OST_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // reset and wake sources
    input wire logic power_on_detect,
    input wire logic brownout_detect,
    input wire logic ext_reset_pin_b,
    input wire logic watchdog_timeout,
    input wire logic interrupt_wake,
    input wire logic sleep_request,
    input wire logic brownout_sw_enable,
    // programming port
    input wire logic prog_mode,
    input wire power_up_reset_pkg::prog_cmd_t prog_cmd,
    input wire logic [13:0] prog_addr,
    input wire logic [15:0] prog_wdata,
    output logic [15:0] prog_rdata,
    output logic prog_rvalid,
    // core control
    output logic core_reset_b,
    output logic sleeping,
    output logic wake_pulse,
    // decoded configuration
    output logic [2:0] oscillator_select,
    output logic crystal_mode,
    output logic internal_oscillator_option,
    output logic low_power_crystal_option,
    output logic watchdog_timer_enable,
    output logic code_protect_b,
    output logic data_protect_b,
    output logic two_speed_startup_enable,
    output logic fail_safe_clock_monitor_enable
);
    import power_up_reset_pkg::*;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic in_cfg_space(input logic [13:0] a);
        in_cfg_space = (a >= `CFG_SPACE_LO) && (a <= `CFG_SPACE_HI);
    endfunction

    function automatic logic is_crystal(input logic [2:0] osc);
        is_crystal = (osc <= `OSC_LAST_CRYSTAL);
    endfunction

    // ****************************************************************
    // configuration word
    // ****************************************************************
    logic [15:0] config_reg;
    logic [15:0] config_next;
    logic cfg_hit;

    assign cfg_hit = prog_mode && (prog_addr == `CFG_WORD_ADDR);

    always_comb begin
        config_next = config_reg;
        if (cfg_hit && prog_cmd == PROG_WRITE) begin
            config_next = config_reg & (prog_wdata | ~`CFG_IMPL_MASK) & `CFG_IMPL_MASK;
        end else if (cfg_hit && prog_cmd == PROG_ERASE) begin
            config_next = `CFG_ERASED;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            config_reg <= `CFG_ERASED;
        end else begin
            config_reg <= config_next;
        end
    end

    // programming reads answer one cycle later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_rdata <= `CFG_ZERO;
            prog_rvalid <= 1'b0;
        end else begin
            prog_rvalid <= prog_mode && prog_cmd == PROG_READ && in_cfg_space(prog_addr);
            if (cfg_hit && prog_cmd == PROG_READ) begin
                prog_rdata <= config_reg;
            end else begin
                prog_rdata <= `CFG_ZERO;
            end
        end
    end

    // decoded options
    logic [2:0] osc_field;
    logic [1:0] bor_field;
    assign osc_field = config_reg[`CFG_OSC_MSB:`CFG_OSC_LSB];
    assign bor_field = config_reg[`CFG_BOR_MSB:`CFG_BOR_LSB];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oscillator_select <= 3'(`CFG_ERASED >> `CFG_OSC_LSB);
            crystal_mode <= 1'b0;
            internal_oscillator_option <= 1'b0;
            low_power_crystal_option <= 1'b0;
            watchdog_timer_enable <= 1'b1;
            code_protect_b <= 1'b1;
            data_protect_b <= 1'b1;
            two_speed_startup_enable <= 1'b1;
            fail_safe_clock_monitor_enable <= 1'b1;
        end else begin
            oscillator_select <= osc_field;
            crystal_mode <= is_crystal(osc_field);
            internal_oscillator_option <= (osc_field == `OSC_INTERNAL_IO)
                || (osc_field == `OSC_INTERNAL_CLKOUT);
            low_power_crystal_option <= (osc_field == `OSC_LOW_POWER_CRYSTAL);
            watchdog_timer_enable <= config_reg[`CFG_WDT_EN_BIT];
            code_protect_b <= config_reg[`CFG_CODE_PROT_BIT];
            data_protect_b <= config_reg[`CFG_DATA_PROT_BIT];
            two_speed_startup_enable <= config_reg[`CFG_TWO_SPEED_BIT];
            fail_safe_clock_monitor_enable <= config_reg[`CFG_FAIL_SAFE_BIT];
        end
    end

    // ****************************************************************
    // reset sources
    // ****************************************************************
    seq_state_t state_reg;
    seq_state_t state_next;
    logic power_up_delay_timer_enabled;
    logic brownout_enabled;
    logic brownout_active;
    logic ext_reset_active;
    logic wdt_reset;
    logic any_source;

    // programmed power-up bit turns the delay timer on
    assign power_up_delay_timer_enabled = !config_reg[`CFG_POWER_UP_DELAY_TIMER_BIT];

    always_comb begin
        case (bor_field)
            `BOR_OFF: brownout_enabled = 1'b0;
            `BOR_SOFTWARE: brownout_enabled = brownout_sw_enable;
            `BOR_RUN_ONLY: brownout_enabled = (state_reg != ST_SLEEP);
            default: brownout_enabled = 1'b1;
        endcase
    end

    assign brownout_active = brownout_detect && brownout_enabled;
    assign ext_reset_active = !ext_reset_pin_b && config_reg[`CFG_MCLR_EN_BIT];
    assign wdt_reset = watchdog_timeout && config_reg[`CFG_WDT_EN_BIT] && (state_reg != ST_SLEEP);
    assign any_source = power_on_detect || brownout_active || ext_reset_active || wdt_reset || prog_mode;

    // ****************************************************************
    // pending start-up delays
    // ****************************************************************
    logic need_power_up_delay_timer_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            need_power_up_delay_timer_reg <= 1'b1;
        end else if (brownout_active) begin
            need_power_up_delay_timer_reg <= 1'b1;
        end else if (power_on_detect) begin
            need_power_up_delay_timer_reg <= power_up_delay_timer_enabled;
        end else if (state_reg == ST_POWER_UP_DELAY_TIMER) begin
            need_power_up_delay_timer_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // start-up timers
    // ****************************************************************
    logic power_up_delay_timer_start;
    logic ost_start;
    logic power_up_delay_timer_done;
    logic ost_done;
    logic timer_abort;

    assign timer_abort = any_source;

    startup_timer #(
        .CYCLES(POWER_UP_DELAY_TIMER_CYCLES)
    ) power_up_delay_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(power_up_delay_timer_start),
        .abort(timer_abort),
        .running(),
        .done(power_up_delay_timer_done)
    );

    startup_timer #(
        .CYCLES(OST_CYCLES)
    ) oscillator_startup_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(ost_start),
        .abort(timer_abort),
        .running(),
        .done(ost_done)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic wake_event;
    assign wake_event = (watchdog_timeout && config_reg[`CFG_WDT_EN_BIT]) || interrupt_wake;

    always_comb begin
        state_next = state_reg;
        power_up_delay_timer_start = 1'b0;
        ost_start = 1'b0;
        case (state_reg)
            ST_HOLD: begin
                if (!any_source) begin
                    if (need_power_up_delay_timer_reg) begin
                        state_next = ST_POWER_UP_DELAY_TIMER;
                        power_up_delay_timer_start = 1'b1;
                    end else if (is_crystal(osc_field)) begin
                        state_next = ST_OST;
                        ost_start = 1'b1;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_POWER_UP_DELAY_TIMER: begin
                if (any_source) begin
                    state_next = ST_HOLD;
                end else if (power_up_delay_timer_done) begin
                    if (is_crystal(osc_field)) begin
                        state_next = ST_OST;
                        ost_start = 1'b1;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_OST: begin
                if (any_source) begin
                    state_next = ST_HOLD;
                end else if (ost_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (any_source) begin
                    state_next = ST_HOLD;
                end else if (sleep_request) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (any_source) begin
                    state_next = ST_HOLD;
                end else if (wake_event) begin
                    if (is_crystal(osc_field)) begin
                        state_next = ST_OST;
                        ost_start = 1'b1;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // core outputs
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_reset_b <= 1'b0;
            sleeping <= 1'b0;
            wake_pulse <= 1'b0;
        end else begin
            core_reset_b <= (state_next == ST_RUN) || (state_next == ST_SLEEP);
            sleeping <= (state_next == ST_SLEEP);
            wake_pulse <= (state_reg == ST_SLEEP) && (state_next != ST_SLEEP);
        end
    end
endmodule

// [hw/power_up_reset_regs.svh]
`ifndef POWER_UP_RESET_REGS_SVH
`define POWER_UP_RESET_REGS_SVH

// ****************************************************************
// configuration word placement
// ****************************************************************
`define CFG_WORD_ADDR 14'h2007
`define CFG_SPACE_LO 14'h2000
`define CFG_SPACE_HI 14'h3FFF
`define CFG_ERASED 16'h0FFF
`define CFG_IMPL_MASK 16'h0FFF
`define CFG_ZERO 16'h0000

// ****************************************************************
// configuration word fields
// ****************************************************************
`define CFG_OSC_LSB 0
`define CFG_OSC_MSB 2
`define CFG_WDT_EN_BIT 3
`define CFG_POWER_UP_DELAY_TIMER_BIT 4
`define CFG_MCLR_EN_BIT 5
`define CFG_CODE_PROT_BIT 6
`define CFG_DATA_PROT_BIT 7
`define CFG_BOR_LSB 8
`define CFG_BOR_MSB 9
`define CFG_TWO_SPEED_BIT 10
`define CFG_FAIL_SAFE_BIT 11

// ****************************************************************
// field encodings
// ****************************************************************
`define OSC_LOW_POWER_CRYSTAL 3'h0
`define OSC_LAST_CRYSTAL 3'h2
`define OSC_INTERNAL_IO 3'h4
`define OSC_INTERNAL_CLKOUT 3'h5
`define BOR_OFF 2'h0
`define BOR_SOFTWARE 2'h1
`define BOR_RUN_ONLY 2'h2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 100
`define POWER_UP_DELAY_TIMER_TIME_MS 64
`define POWER_UP_DELAY_TIMER_CYCLES ((`POWER_UP_DELAY_TIMER_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OST_CYCLES 1024

`endif

// [hw/power_up_reset_pkg.sv]
package power_up_reset_pkg;

    typedef enum logic [4:0] {
        ST_HOLD  = 5'h01,
        ST_POWER_UP_DELAY_TIMER  = 5'h02,
        ST_OST   = 5'h04,
        ST_RUN   = 5'h08,
        ST_SLEEP = 5'h10
    } seq_state_t;

    typedef enum logic [1:0] {
        PROG_NONE  = 2'h0,
        PROG_READ  = 2'h1,
        PROG_WRITE = 2'h2,
        PROG_ERASE = 2'h3
    } prog_cmd_t;

endpackage

// [hw/startup_timer.sv]
`timescale 1ns/10ps
module startup_timer #(
    parameter int unsigned CYCLES = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic start,
    input wire logic abort,
    // status
    output logic running,
    output logic done
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

    logic [W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running <= 1'b0;
            end else if (start) begin
                count_reg <= LOAD;
                running <= 1'b1;
            end else if (running) begin
                if (count_reg == '0) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg - W'(1);
                end
            end
        end
    end
endmodule

// [tb/power_up_reset_props.sv]
`timescale 1ns/10ps
module power_up_reset_props #(
    parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = 1,
    parameter int unsigned OST_CYCLES = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // sources
    input wire logic power_on_detect,
    input wire logic interrupt_wake,
    // programming port
    input wire logic prog_mode,
    input wire power_up_reset_pkg::prog_cmd_t prog_cmd,
    input wire logic [13:0] prog_addr,
    input wire logic [15:0] prog_rdata,
    input wire logic prog_rvalid,
    // core control and decode
    input wire logic core_reset_b,
    input wire logic sleeping,
    input wire logic wake_pulse,
    input wire logic [2:0] oscillator_select,
    input wire logic crystal_mode,
    input wire logic internal_oscillator_option
);
    import power_up_reset_pkg::*;
    // ****************
    // helpers and checks
    // ****************
    localparam int WAKE_MAX = (OST_CYCLES < 900) ? OST_CYCLES + 8 : 1000;
    int unsigned low_cnt;
    logic first_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) low_cnt <= 0;
        else if (core_reset_b) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end
    // first release after cold reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) first_reg <= 1'b1;
        else if (core_reset_b) first_reg <= 1'b0;
    end
    chk_rvalid_cause:
    assert property (prog_rvalid |-> $past(prog_mode) && $past(prog_cmd) == PROG_READ && $past(prog_addr) >= 14'h2000)
        else $error("read answer without a legal read");
    chk_rdata_zero:
    assert property (prog_rvalid && $past(prog_addr) != 14'h2007 |-> prog_rdata == 16'h0000)
        else $error("nonzero data outside config word");
    chk_por_hold:
    assert property (power_on_detect |=> !core_reset_b) else $error("power-on did not hold reset");
    chk_prog_hold:
    assert property (prog_mode |=> !core_reset_b) else $error("programming did not hold reset");
    chk_osc_class:
    assert property (internal_oscillator_option == (oscillator_select inside {3'h4, 3'h5})
        && crystal_mode == (oscillator_select <= 3'h2)) else $error("oscillator option decode wrong");
    chk_first_delay:
    assert property ($rose(core_reset_b) && first_reg |-> low_cnt >= POWER_UP_DELAY_TIMER_CYCLES)
        else $error("first release before delay");
    chk_wake_pulse:
    assert property ($fell(sleeping) |-> wake_pulse) else $error("sleep left without wake pulse");
    chk_int_wake:
    assert property (sleeping && interrupt_wake |-> ##[1:WAKE_MAX] wake_pulse)
        else $error("interrupt did not wake");
endmodule
bind power_up_reset_and_config_word power_up_reset_props #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES), .OST_CYCLES(OST_CYCLES)) chk_u (
    .clk, .rst_b, .power_on_detect, .interrupt_wake, .prog_mode, .prog_cmd, .prog_addr, .prog_rdata,
    .prog_rvalid, .core_reset_b, .sleeping, .wake_pulse, .oscillator_select, .crystal_mode,
    .internal_oscillator_option);

// [tb/power_up_reset_and_config_word_tb_top.sv]
`timescale 1ns/10ps
module power_up_reset_and_config_word_tb_top;
    import power_up_reset_pkg::*;
    // ****************
    // stimulus and checking
    // ****************
    localparam int PW = 20;
    localparam int OS = 8;
    logic clk = 1'b0, rst_b = 1'b0, power_on_detect = 1'b0, brownout_detect = 1'b0;
    logic ext_reset_pin_b = 1'b1, watchdog_timeout = 1'b0, interrupt_wake = 1'b0;
    logic sleep_request = 1'b0, brownout_sw_enable = 1'b0, prog_mode = 1'b0;
    prog_cmd_t prog_cmd = PROG_NONE;
    logic [13:0] prog_addr = 14'h0000;
    logic [15:0] prog_wdata = 16'h0000, prog_rdata, cfg = 16'h0FFF;
    logic [31:0] seed = 32'h3FA0;
    logic [2:0] oscillator_select;
    logic prog_rvalid, core_reset_b, sleeping, wake_pulse, crystal_mode, internal_oscillator_option;
    logic low_power_crystal_option, watchdog_timer_enable, code_protect_b, data_protect_b;
    logic two_speed_startup_enable, fail_safe_clock_monitor_enable;
    logic [15:0] q[$];
    int fails = 0, checks_done = 0;
    int n;

    power_up_reset_and_config_word #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .OST_CYCLES(OS)) dut_u (
        .clk, .rst_b, .power_on_detect, .brownout_detect, .ext_reset_pin_b, .watchdog_timeout,
        .interrupt_wake, .sleep_request, .brownout_sw_enable, .prog_mode, .prog_cmd, .prog_addr,
        .prog_wdata, .prog_rdata, .prog_rvalid, .core_reset_b, .sleeping, .wake_pulse,
        .oscillator_select, .crystal_mode, .internal_oscillator_option, .low_power_crystal_option,
        .watchdog_timer_enable, .code_protect_b, .data_protect_b, .two_speed_startup_enable,
        .fail_safe_clock_monitor_enable);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic done(string nm);
        $display("test %s done", nm);
    endtask
    // expected read data is noted when the read is issued
    task automatic prog(prog_cmd_t c, logic [13:0] a, logic [15:0] d);
        @(negedge clk);
        prog_cmd = c;
        prog_addr = a;
        prog_wdata = d;
        if (prog_mode && c == PROG_READ && a >= 14'h2000) q.push_back(a == 14'h2007 ? cfg : 16'h0000);
        if (prog_mode && a == 14'h2007 && c == PROG_WRITE) cfg = cfg & d;
        if (prog_mode && a == 14'h2007 && c == PROG_ERASE) cfg = 16'h0FFF;
        @(negedge clk);
        prog_cmd = PROG_NONE;
    endtask
    task automatic up(int lo, int hi);
        n = 0;
        while (core_reset_b !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200) begin
            fails++;
            print_verdict();
        end
        check("release_time", 16'(n >= lo && n <= hi), 16'h1);
    endtask
    task automatic decode();
        check("decode", 16'({fail_safe_clock_monitor_enable, two_speed_startup_enable, data_protect_b,
            code_protect_b, watchdog_timer_enable, oscillator_select}), 16'({cfg[11:10], cfg[7:6], cfg[3], cfg[2:0]}));
        check("osc_class", 16'({low_power_crystal_option, crystal_mode, internal_oscillator_option}),
            16'({cfg[2:0] == 3'h0, cfg[2:0] <= 3'h2, cfg[2:0] inside {3'h4, 3'h5}}));
    endtask

    always @(posedge clk) begin
        if (rst_b && prog_rvalid === 1'b1) begin
            if (q.size() == 0) check("rvalid", 16'h1, 16'h0);
            else check("rdata", prog_rdata, q.pop_front());
        end
    end

    initial begin
        forever #50 clk = ~clk;
    end

    initial begin
        cyc(4);
        rst_b = 1'b1;
        up(PW, PW + 6);
        done("power_up");
        prog_mode = 1'b1;
        cyc(2);
        check("core_reset_b", 16'(core_reset_b), 16'h0);
        prog(PROG_READ, 14'h2007, 16'h0000);
        prog(PROG_READ, 14'h2000, 16'h0000);
        prog(PROG_READ, 14'h3FFF, 16'h0000);
        prog(PROG_READ, 14'h1FFF, 16'h0000);
        prog(PROG_WRITE, 14'h2007, 16'hFFFC);
        seed = lfsr(seed);
        prog(PROG_WRITE, 14'h2007, seed[15:0] | 16'h033C);
        prog(PROG_READ, 14'h2007, 16'h0000);
        prog_mode = 1'b0;
        up(0, 3);
        decode();
        prog(PROG_READ, 14'h2007, 16'h0000);
        done("config");
        ext_reset_pin_b = 1'b0;
        cyc(3);
        check("core_reset_b", 16'(core_reset_b), 16'h0);
        ext_reset_pin_b = 1'b1;
        up(0, 3);
        brownout_detect = 1'b1;
        cyc(3);
        brownout_detect = 1'b0;
        up(PW, PW + 6);
        done("resets");
        for (int k = 0; k < 3; k++) begin
            sleep_request = 1'b1;
            cyc(1);
            sleep_request = 1'b0;
            check("sleeping", 16'(sleeping), 16'h1);
            cyc(2);
            if (k == 0) interrupt_wake = 1'b1;
            else if (k == 1) watchdog_timeout = 1'b1;
            else ext_reset_pin_b = 1'b0;
            n = 0;
            while (sleeping !== 1'b0 && n < 50) begin
                cyc(1);
                n++;
            end
            if (n >= 50) begin
                fails++;
                print_verdict();
            end
            check("wake_pulse", 16'(wake_pulse), 16'h1);
            interrupt_wake = 1'b0;
            watchdog_timeout = 1'b0;
            ext_reset_pin_b = 1'b1;
            up(0, 3);
        end
        done("sleep");
        prog_mode = 1'b1;
        prog(PROG_ERASE, 14'h2007, 16'h0000);
        prog(PROG_READ, 14'h2007, 16'h0000);
        prog(PROG_WRITE, 14'h2007, 16'hFFE8);
        prog(PROG_READ, 14'h2007, 16'h0000);
        prog_mode = 1'b0;
        up(OS, OS + 6);
        decode();
        power_on_detect = 1'b1;
        cyc(3);
        power_on_detect = 1'b0;
        up(PW + OS, PW + OS + 8);
        done("crystal");
        // software brown-out mode: ignored until enabled
        prog_mode = 1'b1;
        prog(PROG_ERASE, 14'h2007, 16'h0000);
        prog(PROG_WRITE, 14'h2007, 16'hFDFC);
        prog_mode = 1'b0;
        up(0, 3);
        decode();
        brownout_detect = 1'b1;
        cyc(3);
        check("bor_sw_off", 16'(core_reset_b), 16'h1);
        brownout_sw_enable = 1'b1;
        cyc(2);
        check("bor_sw_on", 16'(core_reset_b), 16'h0);
        brownout_detect = 1'b0;
        up(PW, PW + 6);
        done("brownout_modes");
        cyc(3);
        check("pending", 16'(q.size()), 16'h0);
        print_verdict();
    end
endmodule
